//--- core/atc_coef_mem.sv
`timescale 1ns/1ps
module atc_coef_mem
#(
  parameter int W  = 16,
  parameter int AW = 4
)
(
  input  wire logic          core_clk,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [W-1:0]  wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [W-1:0]  rd_data
);

  logic [W-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge core_clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule // atc_coef_mem

//--- core/atc_compare.sv
`timescale 1ns/1ps
module atc_compare
  import atc_pkg::*;
#(
  parameter int NCH   = 8,
  parameter int RAW_W = 12
)
(
  input  wire logic                 core_clk,
  input  wire logic                 srst,
  input  wire logic [ATC_AW-1:0]    reg_addr,
  input  wire logic [ATC_DW-1:0]    reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic      [ATC_DW-1:0]    reg_rdata,
  input  wire logic                 scan_start,
  input  wire logic [NCH*RAW_W-1:0] raw_data,
  output logic                      cmp_result,
  output logic                      disp_upd,
  output logic      [ATC_DW-1:0]    disp_ctrl,
  output logic      [ATC_VAL_W-1:0] disp_const1,
  output logic      [ATC_VAL_W-1:0] disp_const2
);

  generate
    if (NCH < 1 || NCH > (1 << ATC_CH_W) || RAW_W < 1 ||
        RAW_W > ATC_VAL_W - ATC_COEF_W - 1)
    begin : g_bad_cfg
      $error("atc_compare: unsupported NCH or RAW_W");
    end
  endgenerate
  typedef enum logic [2:0] {
    ST_IDLE, ST_G1, ST_O1, ST_G2, ST_O2, ST_CMP
  } atc_state_t;

  logic [ATC_DW-1:0]     ctrl_r,   ctrl_nxt;
  logic [ATC_VAL_W-1:0]  const1_r, const1_nxt;
  logic [ATC_VAL_W-1:0]  const2_r, const2_nxt;
  logic [ATC_CIDX_W-1:0] cidx_r,   cidx_nxt;
  logic [ATC_DW-1:0]     rdata_r,  rdata_nxt;
  logic                  coef_we;
  atc_state_t              state_r,  state_nxt;
  logic signed [ATC_COEF_W-1:0] gain_r, gain_nxt;
  logic [ATC_VAL_W-1:0]    op1_r,    op1_nxt;
  logic [ATC_VAL_W-1:0]    op2_r,    op2_nxt;
  logic [RAW_W-1:0]        raw1_r,   raw1_nxt;
  logic [RAW_W-1:0]        raw2_r,   raw2_nxt;
  logic                    result_r, result_nxt;
  logic                    upd_r,    upd_nxt;
  logic [ATC_DW-1:0]       dctrl_r,  dctrl_nxt;
  logic [ATC_VAL_W-1:0]    dc1_r,    dc1_nxt;
  logic [ATC_VAL_W-1:0]    dc2_r,    dc2_nxt;
  logic [ATC_CIDX_W-1:0]   mem_raddr;
  logic [ATC_COEF_W-1:0]   mem_rdata;
  logic [2:0]          rel;
  logic [ATC_CH_W-1:0] ch1;
  logic [ATC_CH_W-1:0] ch2;
  logic                busy;
  assign rel  = ctrl_r[ATC_REL_LSB +: ATC_REL_W];
  assign ch1  = ctrl_r[ATC_CH1_LSB +: ATC_CH_W];
  assign ch2  = ctrl_r[ATC_CH2_LSB +: ATC_CH_W];
  assign busy = (state_r != ST_IDLE);

  // Scaled value in the signed value domain
  function automatic logic [ATC_VAL_W-1:0] scale(
    input logic signed [ATC_COEF_W-1:0] g,
    input logic        [RAW_W-1:0]      raw,
    input logic signed [ATC_COEF_W-1:0] off
  );
    logic signed [ATC_VAL_W-1:0] rx;
    rx = ATC_VAL_W'({1'b0, raw});
    return ATC_VAL_W'(ATC_VAL_W'(g) * rx + ATC_VAL_W'(off));
  endfunction

  // Channels past NCH read as zero
  logic [RAW_W-1:0] raw_ch [0:(1<<ATC_CH_W)-1];
  for (genvar i = 0; i < (1 << ATC_CH_W); i++)
  begin : g_ch
    if (i < NCH)
    begin : g_used
      assign raw_ch[i] = raw_data[i*RAW_W +: RAW_W];
    end
    else
    begin : g_unused
      assign raw_ch[i] = '0;
    end
  end

  function automatic logic relation(
    input logic        [2:0]           r,
    input logic signed [ATC_VAL_W-1:0] a,
    input logic signed [ATC_VAL_W-1:0] b
  );
    case (r)
      ATC_REL_LT: return (a < b);
      ATC_REL_GT: return (a > b);
      ATC_REL_LE: return (a <= b);
      ATC_REL_GE: return (a >= b);
      ATC_REL_NE: return (a != b);
      ATC_REL_EQ: return (a == b);
      default:    return 1'b0;
    endcase
  endfunction
  atc_coef_mem #(
    .W  (ATC_COEF_W),
    .AW (ATC_CIDX_W)
  ) u_coef (
    .core_clk (core_clk),
    .wr_en    (coef_we),
    .wr_addr  (cidx_r),
    .wr_data  (reg_wdata[ATC_COEF_W-1:0]),
    .rd_addr  (mem_raddr),
    .rd_data  (mem_rdata)
  );
  always_comb
  begin
    ctrl_nxt   = ctrl_r;
    const1_nxt = const1_r;
    const2_nxt = const2_r;
    cidx_nxt   = cidx_r;
    rdata_nxt  = '0;
    coef_we    = 1'b0;
    if (reg_wr)
    begin
      case (reg_addr)
        ATC_REG_CTRL:     ctrl_nxt   = reg_wdata;
        ATC_REG_CONST1:   const1_nxt = reg_wdata;
        ATC_REG_CONST2:   const2_nxt = reg_wdata;
        ATC_REG_COEF_IDX: cidx_nxt   = reg_wdata[ATC_CIDX_W-1:0];
        ATC_REG_COEF_DATA:
        begin
          // Auto-advance lets software stream gain, offset, gain...
          coef_we  = 1'b1;
          cidx_nxt = cidx_r + 1'b1;
        end
        default: ;
      endcase
    end
    if (reg_rd)
    begin
      case (reg_addr)
        ATC_REG_CTRL:     rdata_nxt = ctrl_r;
        ATC_REG_CONST1:   rdata_nxt = const1_r;
        ATC_REG_CONST2:   rdata_nxt = const2_r;
        ATC_REG_COEF_IDX: rdata_nxt = ATC_DW'(cidx_r);
        ATC_REG_STATUS:
        begin
          rdata_nxt[ATC_STAT_RESULT] = result_r;
          rdata_nxt[ATC_STAT_BUSY]   = busy;
        end
        ATC_REG_OP1:      rdata_nxt = op1_r;
        ATC_REG_OP2:      rdata_nxt = op2_r;
        default:          rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      ctrl_r   <= ATC_CTRL_RST;
      const1_r <= ATC_CONST_RST;
      const2_r <= ATC_CONST_RST;
      cidx_r   <= '0;
      rdata_r  <= '0;
    end
    else
    begin
      ctrl_r   <= ctrl_nxt;
      const1_r <= const1_nxt;
      const2_r <= const2_nxt;
      cidx_r   <= cidx_nxt;
      rdata_r  <= rdata_nxt;
    end
  end
  always_comb
  begin
    state_nxt  = state_r;
    gain_nxt   = gain_r;
    op1_nxt    = op1_r;
    op2_nxt    = op2_r;
    raw1_nxt   = raw1_r;
    raw2_nxt   = raw2_r;
    result_nxt = result_r;
    upd_nxt    = 1'b0;
    dctrl_nxt  = dctrl_r;
    dc1_nxt    = dc1_r;
    dc2_nxt    = dc2_r;
    mem_raddr  = {ch1, ATC_SEL_GAIN};
    case (state_r)
      ST_IDLE:
      begin
        if (scan_start)
        begin
          raw1_nxt  = raw_ch[ch1];
          raw2_nxt  = raw_ch[ch2];
          state_nxt = ST_G1;
        end
      end
      ST_G1:
      begin
        mem_raddr = {ch1, ATC_SEL_GAIN};
        state_nxt = ST_O1;
      end
      ST_O1:
      begin
        mem_raddr = {ch1, ATC_SEL_OFF};
        gain_nxt  = mem_rdata;
        state_nxt = ST_G2;
      end
      ST_G2:
      begin
        mem_raddr = {ch2, ATC_SEL_GAIN};
        op1_nxt   = ctrl_r[ATC_OP1_CONST] ? const1_r
                    : scale(gain_r, raw1_r, mem_rdata);
        state_nxt = ST_O2;
      end
      ST_O2:
      begin
        mem_raddr = {ch2, ATC_SEL_OFF};
        gain_nxt  = mem_rdata;
        state_nxt = ST_CMP;
      end
      ST_CMP:
      begin
        op2_nxt    = ctrl_r[ATC_OP2_CONST] ? const2_r
                     : scale(gain_r, raw2_r, mem_rdata);
        result_nxt = relation(rel, op1_r, op2_nxt);
        if (ctrl_r[ATC_LINK_BIT])
        begin
          upd_nxt   = 1'b1;
          dctrl_nxt = ctrl_r;
          dc1_nxt   = const1_r;
          dc2_nxt   = const2_r;
        end
        state_nxt  = ST_IDLE;
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      state_r  <= ST_IDLE;
      gain_r   <= '0;
      op1_r    <= '0;
      op2_r    <= '0;
      raw1_r   <= '0;
      raw2_r   <= '0;
      result_r <= 1'b0;
      upd_r    <= 1'b0;
      dctrl_r  <= ATC_CTRL_RST;
      dc1_r    <= ATC_CONST_RST;
      dc2_r    <= ATC_CONST_RST;
    end
    else
    begin
      state_r  <= state_nxt;
      gain_r   <= gain_nxt;
      op1_r    <= op1_nxt;
      op2_r    <= op2_nxt;
      raw1_r   <= raw1_nxt;
      raw2_r   <= raw2_nxt;
      result_r <= result_nxt;
      upd_r    <= upd_nxt;
      dctrl_r  <= dctrl_nxt;
      dc1_r    <= dc1_nxt;
      dc2_r    <= dc2_nxt;
    end
  end
  assign reg_rdata   = rdata_r;
  assign cmp_result  = result_r;
  assign disp_upd    = upd_r;
  assign disp_ctrl   = dctrl_r;
  assign disp_const1 = dc1_r;
  assign disp_const2 = dc2_r;

endmodule // atc_compare

//--- core/atc_pkg.sv
package atc_pkg;

  // Register port
  localparam int         ATC_AW            = 8;
  localparam int         ATC_DW            = 32;
  localparam logic [7:0] ATC_REG_CTRL      = 8'h00;
  localparam logic [7:0] ATC_REG_CONST1    = 8'h04;
  localparam logic [7:0] ATC_REG_CONST2    = 8'h08;
  localparam logic [7:0] ATC_REG_COEF_IDX  = 8'h0C;
  localparam logic [7:0] ATC_REG_COEF_DATA = 8'h10;
  localparam logic [7:0] ATC_REG_STATUS    = 8'h14;
  localparam logic [7:0] ATC_REG_OP1       = 8'h18;
  localparam logic [7:0] ATC_REG_OP2       = 8'h1C;

  // Control word layout
  localparam int ATC_REL_LSB   = 0;
  localparam int ATC_REL_W     = 3;
  localparam int ATC_OP1_CONST = 3;
  localparam int ATC_OP2_CONST = 4;
  localparam int ATC_CH1_LSB   = 8;
  localparam int ATC_CH2_LSB   = 12;
  localparam int ATC_CH_W      = 3;
  localparam int ATC_LINK_BIT  = 16;
  localparam logic [31:0] ATC_CTRL_RST  = 32'h0000_0000;
  localparam logic [31:0] ATC_CONST_RST = 32'h0000_0000;

  // Status word layout
  localparam int ATC_STAT_RESULT = 0;
  localparam int ATC_STAT_BUSY   = 1;

  // Relation codes
  localparam logic [2:0] ATC_REL_LT = 3'h0;
  localparam logic [2:0] ATC_REL_GT = 3'h1;
  localparam logic [2:0] ATC_REL_LE = 3'h2;
  localparam logic [2:0] ATC_REL_GE = 3'h3;
  localparam logic [2:0] ATC_REL_NE = 3'h4;
  localparam logic [2:0] ATC_REL_EQ = 3'h5;

  // Coefficient storage: entry {channel, sel}
  localparam int   ATC_COEF_W   = 16;
  localparam int   ATC_VAL_W    = 32;
  localparam int   ATC_CIDX_W   = ATC_CH_W + 1;
  localparam logic ATC_SEL_GAIN = 1'b0;
  localparam logic ATC_SEL_OFF  = 1'b1;

endpackage

//--- tb/atc_compare_properties.sv
`timescale 1ns/1ps
module atc_compare_chk
  import atc_pkg::*;
(
  input wire logic                 core_clk,
  input wire logic                 srst,
  input wire logic                 scan_start,
  input wire logic                 cmp_result,
  input wire logic                 disp_upd,
  input wire logic [ATC_DW-1:0]    disp_ctrl,
  input wire logic [ATC_VAL_W-1:0] disp_const1,
  input wire logic [ATC_VAL_W-1:0] disp_const2
);
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;

  // Scan tracker: starts refused while counting
  always_comb
  begin
    cnt_nxt = cnt_r;
    if (cnt_r == 3'h5)
      cnt_nxt = 3'h0;
    else if (cnt_r != 3'h0 || scan_start)
      cnt_nxt = cnt_r + 3'h1;
  end

  always_ff @(posedge core_clk)
    cnt_r <= srst ? 3'h0 : cnt_nxt;

  function automatic logic rel_ok(logic [2:0] r, logic signed [31:0] a,
                                  logic signed [31:0] b);
    case (r)
      ATC_REL_LT: return a < b;
      ATC_REL_GT: return a > b;
      ATC_REL_LE: return a <= b;
      ATC_REL_GE: return a >= b;
      ATC_REL_NE: return a != b;
      ATC_REL_EQ: return a == b;
      default: return 1'b0;
    endcase
  endfunction

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  // Reset clears outputs, so skip the edge right after a reset cycle
  a_result_held: assert property (
    !$stable(cmp_result) && !$past(srst) |-> $past(cnt_r) == 3'h5)
    else $error("result moved outside a scan end");
  a_upd_at_end: assert property (
    disp_upd |-> $past(cnt_r) == 3'h5)
    else $error("display update off scan end");
  a_upd_pulse: assert property (
    disp_upd |=> !disp_upd)
    else $error("display update longer than one cycle");
  a_upd_link: assert property (
    disp_upd |-> disp_ctrl[ATC_LINK_BIT])
    else $error("display update without link");
  a_disp_hold: assert property (
    !disp_upd && !$past(srst) |-> $stable(disp_ctrl) &&
      $stable(disp_const1) && $stable(disp_const2))
    else $error("display copy changed without update");
  a_rel_consts: assert property (
    disp_upd && disp_ctrl[4:3] == 2'h3 |-> cmp_result ==
      rel_ok(disp_ctrl[2:0], disp_const1, disp_const2))
    else $error("result disagrees with relation");
  a_lt_strict: assert property (
    disp_upd && disp_ctrl[4:0] == 5'h18 && disp_const1 == disp_const2
      |-> !cmp_result)
    else $error("less-than true on equal operands");
  a_reset_clear: assert property (
    disable iff (1'b0) srst |=> !cmp_result && !disp_upd)
    else $error("outputs not cleared by reset");

  c_upd: cover property (disp_upd);
  c_true: cover property (disp_upd && cmp_result);
  c_refused: cover property (scan_start && cnt_r != 3'h0);
endmodule // atc_compare_chk

bind atc_compare atc_compare_chk atc_compare_chk_i (.core_clk, .srst,
  .scan_start, .cmp_result, .disp_upd, .disp_ctrl, .disp_const1,
  .disp_const2);

//--- tb/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import atc_pkg::*;
;
  logic        core_clk = 1'b0;
  logic        srst = 1'b1;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        scan_start = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic [95:0] raw_data = '0;
  logic [31:0] reg_rdata, disp_ctrl, disp_const1, disp_const2;
  logic        cmp_result, disp_upd;
  int          miscompares = 0, checked = 0, upd_cnt = 0;
  int          ca [3] = '{-5, 9, 9};
  int          cb [3] = '{9, 9, -5};

  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) if (disp_upd === 1'b1) upd_cnt++;

  atc_compare atc_compare_i (.core_clk, .srst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .scan_start, .raw_data, .cmp_result,
    .disp_upd, .disp_ctrl, .disp_const1, .disp_const2);

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask

  task automatic pulse();
    @(posedge core_clk);
    scan_start <= 1'b1;
    @(posedge core_clk);
    scan_start <= 1'b0;
  endtask

  task automatic scan(input logic [31:0] ctrl, input logic e);
    wr(ATC_REG_CTRL, ctrl);
    pulse();
    // Display pulse stands one cycle only, look right after it rises
    repeat (5) @(posedge core_clk);
    #1 chk({31'h0, cmp_result}, {31'h0, e});
    chk({31'h0, disp_upd}, {31'h0, ctrl[ATC_LINK_BIT]});
    if (ctrl[ATC_LINK_BIT])
      chk(disp_ctrl, ctrl);
  endtask

  function automatic logic [31:0] mk(logic [2:0] r, logic o1, logic o2,
                                     logic [2:0] c1, logic [2:0] c2,
                                     logic lk);
    return {15'h0, lk, 1'b0, c2, 1'b0, c1, 3'h0, o2, o1, r};
  endfunction

  // Scaled reading with the per-channel coefficients loaded below
  function automatic logic [31:0] sc(int c);
    return 32'((c + 1) * (200 * c + 7) + 40 * c - 100);
  endfunction

  function automatic logic rel(logic [2:0] r, int a, int b);
    case (r)
      ATC_REL_LT: return a < b;
      ATC_REL_GT: return a > b;
      ATC_REL_LE: return a <= b;
      ATC_REL_GE: return a >= b;
      ATC_REL_NE: return a != b;
      ATC_REL_EQ: return a == b;
      default: return 1'b0;
    endcase
  endfunction

  task automatic print_verdict();
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    for (int c = 0; c < 8; c++)
      raw_data[c*12 +: 12] = 12'(200 * c + 7);
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    rd(ATC_REG_STATUS, 32'h0);
    rd(8'h20, 32'h0);
    $display("test reset done");
    for (int r = 0; r < 8; r++)
      for (int p = 0; p < 3; p++)
      begin
        wr(ATC_REG_CONST1, ca[p]);
        wr(ATC_REG_CONST2, cb[p]);
        scan(mk(3'(r), 1'b1, 1'b1, 3'h0, 3'h0, 1'b1),
             rel(3'(r), ca[p], cb[p]));
      end
    $display("test relations done");
    // Coefficient memory has no reset, so load all of it first
    wr(ATC_REG_COEF_IDX, 32'h0);
    for (int c = 0; c < 8; c++)
    begin
      wr(ATC_REG_COEF_DATA, 32'(c + 1));
      wr(ATC_REG_COEF_DATA, 32'(40 * c - 100));
    end
    wr(ATC_REG_CONST2, sc(3));
    scan(mk(ATC_REL_EQ, 1'b0, 1'b1, 3'h3, 3'h0, 1'b1), 1'b1);
    rd(ATC_REG_OP1, sc(3));
    scan(mk(ATC_REL_LT, 1'b0, 1'b1, 3'h3, 3'h0, 1'b0), 1'b0);
    wr(ATC_REG_CONST1, sc(5) + 32'h1);
    scan(mk(ATC_REL_GT, 1'b1, 1'b0, 3'h0, 3'h5, 1'b1), 1'b1);
    chk(disp_const1, sc(5) + 32'h1);
    chk(disp_const2, sc(3));
    rd(ATC_REG_OP2, sc(5));
    scan(mk(ATC_REL_LT, 1'b0, 1'b0, 3'h2, 3'h6, 1'b1), 1'b1);
    wr(ATC_REG_COEF_IDX, 32'h4);
    wr(ATC_REG_COEF_DATA, 32'd20);
    rd(ATC_REG_COEF_IDX, 32'h5);
    scan(mk(ATC_REL_GT, 1'b0, 1'b0, 3'h2, 3'h6, 1'b0), 1'b0);
    rd(ATC_REG_OP1, 32'd8120);
    rd(ATC_REG_OP2, sc(6));
    $display("test channels done");
    wr(ATC_REG_CTRL, mk(ATC_REL_GE, 1'b0, 1'b0, 3'h2, 3'h6, 1'b1));
    upd_cnt = 0;
    pulse();
    rd(ATC_REG_STATUS, 32'h2);
    pulse();
    repeat (12) @(posedge core_clk);
    #1 chk({31'h0, cmp_result}, 32'h0);
    chk(32'(upd_cnt), 32'h1);
    $display("test busy done");
    scan(mk(ATC_REL_LE, 1'b0, 1'b0, 3'h2, 3'h6, 1'b1), 1'b1);
    @(posedge core_clk);
    srst <= 1'b1;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    #1 chk({31'h0, cmp_result}, 32'h0);
    chk(disp_ctrl, ATC_CTRL_RST);
    rd(ATC_REG_CTRL, 32'h0);
    $display("test reset again done");
    print_verdict();
  end

  initial
  begin
    #20000;
    miscompares++;
    print_verdict();
  end
endmodule // tb_top
